/* File: wdsfs_top.sv */
// Purpose: watchdog supervisor with regulator fault mode handling.
// Assumes: serial register fields arrive as same-clock ports; pins are async.
// Notes: strap and enable pin are read once the input filter has settled.
`timescale 1ns/1ps
`include "wdsfs_map.svh"
module wdsfs_top #(
  parameter int CYCLES_PER_MS = `WDSFS_NS_PER_MS / `WDSFS_CLK_NS,
  parameter int INACT_CYCLES = `WDSFS_INACT_MS * CYCLES_PER_MS,
  parameter int GLITCH_CYCLES = 8,
  parameter int PULSE_CYCLES = 16
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire wdsfs_pkg::wdsfs_tri_t controlSelectOrChipSelect,
  input wire wdsfs_pkg::wdsfs_tri_t windowLengthSelectPin,
  input wire logic watchdogTriggerIn,
  input wire logic enablePin,
  input wire logic regulatorUndervoltage,
  input wire logic regulatorOvervoltage,
  input wire logic [1:0] spiModeField,
  input wire logic spiModeWrite,
  input wire logic failsafeEnable,
  input wire logic timeoutModeSelect,
  input wire logic [1:0] periodPrescalerField,
  input wire logic [2:0] periodCodeField,
  input wire logic [1:0] resetThresholdSelect,
  input wire logic wakeEvent,
  output logic supplyResetOutN,
  output logic watchdogResetOutN,
  output logic interruptOutN,
  output logic limpOut,
  output logic [1:0] modeField,
  output logic failsafeActive,
  output logic spiControlActive,
  output logic [3:0] errorCount,
  output logic periodReserved
);
  import wdsfs_pkg::*;

  localparam int SETTLE_CYCLES = GLITCH_CYCLES + 8;
  localparam logic [32*`WDSFS_PERIOD_W-1:0] PERIOD_TABLE = `WDSFS_PERIOD_MS_TABLE;

  // ==========================================================
  // input conditioning
  logic [`WDSFS_IN_W-1:0] pinLvl;
  logic [`WDSFS_IN_W-1:0] pinEdge;

  // [R13] both edges filtered
  wdsfs_deglitch #(
    .WIDTH(`WDSFS_IN_W),
    .FILT_CYCLES(GLITCH_CYCLES)
  ) u_deglitch (
    .sys_clk(sys_clk),
    .rst(rst),
    .rawIn({regulatorOvervoltage, regulatorUndervoltage, enablePin, watchdogTriggerIn,
      windowLengthSelectPin, controlSelectOrChipSelect}),
    .level(pinLvl),
    .edgePulse(pinEdge)
  );

  logic [1:0] selLvl;
  logic [1:0] winLvl;
  logic trigEdge;
  logic enLvl;
  logic uvLvl;
  logic ovLvl;

  // a toggle gives one edge, a pulse gives two and so two services
  assign selLvl = pinLvl[`WDSFS_IN_SEL +: 2];
  assign winLvl = pinLvl[`WDSFS_IN_WIN +: 2];
  assign trigEdge = pinEdge[`WDSFS_IN_TRIG];
  assign enLvl = pinLvl[`WDSFS_IN_EN];
  assign uvLvl = pinLvl[`WDSFS_IN_UV];
  assign ovLvl = pinLvl[`WDSFS_IN_OV];

  // ==========================================================
  // device mode state
  wdsfs_mode_t modeState;
  wdsfs_mode_t next_modeState;
  logic spiCtl;
  logic next_spiCtl;
  logic [31:0] settleCnt;
  logic [31:0] next_settleCnt;
  logic [31:0] inactCnt;
  logic [31:0] next_inactCnt;
  logic inactDone;
  logic inactRun;

  assign inactDone = (inactCnt == 32'(INACT_CYCLES - 1));

  // mode transitions; faults take priority over normal pin or serial requests
  always_comb begin
    next_modeState = modeState;
    next_spiCtl = spiCtl;
    next_settleCnt = settleCnt;
    next_inactCnt = 32'h0;
    inactRun = 1'h0;
    case (modeState)
      DEV_PWRUP: begin
        next_settleCnt = settleCnt + 32'h1;
        if (settleCnt == 32'(SETTLE_CYCLES - 1)) begin
          // [R01] strap capture
          next_spiCtl = (selLvl == `WDSFS_TRI_OPEN);
          next_modeState = enLvl ? DEV_NORMAL : DEV_STANDBY;
        end
      end
      default: begin
        // inactivity timer wraps, so it restarts after each expiry
        inactRun = uvLvl || (ovLvl && !spiCtl && modeState == DEV_SLEEP);
        if (inactRun && !inactDone) begin
          next_inactCnt = inactCnt + 32'h1;
        end
        if (spiCtl && failsafeEnable && (ovLvl || (uvLvl && inactDone))) begin
          // [R20] [R22] [R23] failsafe entry
          next_modeState = DEV_FAILSAFE;
        end else if (spiCtl && ovLvl && modeState != DEV_FAILSAFE) begin
          // [R22] overvoltage to sleep
          next_modeState = DEV_SLEEP;
        end else if (spiCtl && uvLvl && inactDone && modeState != DEV_FAILSAFE) begin
          // [R18] [R20] persisting undervoltage
          next_modeState = DEV_SLEEP;
        end else if (!spiCtl && ovLvl) begin
          // [R21] sleep and periodic recheck
          if (modeState != DEV_SLEEP) begin
            next_modeState = DEV_SLEEP;
            next_inactCnt = 32'h0;
          end else if (inactDone && enLvl) begin
            next_modeState = DEV_NORMAL;
          end
        end else if (!spiCtl && uvLvl && inactDone) begin
          // [R19] enable pin picks mode
          next_modeState = enLvl ? DEV_NORMAL : DEV_SLEEP;
        end else if (modeState == DEV_FAILSAFE) begin
          if (wakeEvent && !uvLvl && !ovLvl) begin
            next_modeState = DEV_STANDBY;
          end
        end else if (!spiCtl) begin
          if (modeState == DEV_NORMAL && !enLvl) begin
            next_modeState = DEV_SLEEP;
          end else if (modeState != DEV_NORMAL && enLvl) begin
            next_modeState = DEV_NORMAL;
          end else if (modeState == DEV_SLEEP && wakeEvent) begin
            next_modeState = DEV_STANDBY;
          end
        end else if (spiModeWrite) begin
          // [R24] mode field decode, reserved code ignored
          case (spiModeField)
            `WDSFS_MODE_STANDBY: next_modeState = DEV_STANDBY;
            `WDSFS_MODE_SLEEP: next_modeState = DEV_SLEEP;
            `WDSFS_MODE_NORMAL: next_modeState = DEV_NORMAL;
            default: next_modeState = modeState;
          endcase
        end else if (modeState == DEV_SLEEP && wakeEvent) begin
          next_modeState = DEV_STANDBY;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      modeState <= DEV_PWRUP;
      spiCtl <= 1'h0;
      settleCnt <= 32'h0;
      inactCnt <= 32'h0;
    end else begin
      modeState <= next_modeState;
      spiCtl <= next_spiCtl;
      settleCnt <= next_settleCnt;
      inactCnt <= next_inactCnt;
    end
  end

  // ==========================================================
  // watchdog period selection
  logic [4:0] periodIdx;
  logic [`WDSFS_PERIOD_W-1:0] spiPeriodMs;
  logic [`WDSFS_PERIOD_W-1:0] periodMs;
  logic [31:0] periodCycles;
  logic [31:0] halfCycles;
  logic timeoutMode;
  logic rsvdPeriod;

  assign periodIdx = {periodCodeField, periodPrescalerField};
  // [R16] period lookup
  assign spiPeriodMs = PERIOD_TABLE[int'(periodIdx) * `WDSFS_PERIOD_W +: `WDSFS_PERIOD_W];

  // [R11] pin window choice
  always_comb begin
    periodMs = spiPeriodMs;
    if (!spiCtl) begin
      case (winLvl)
        `WDSFS_TRI_HIGH: periodMs = `WDSFS_PIN_WIN_HIGH_MS;
        `WDSFS_TRI_LOW: periodMs = `WDSFS_PIN_WIN_LOW_MS;
        default: periodMs = `WDSFS_PIN_WIN_OPEN_MS;
      endcase
    end
  end

  // 20240 ms at 100 MHz still fits 32 bits
  assign periodCycles = 32'(periodMs * 32'(CYCLES_PER_MS));
  // [R12] closed half first
  assign halfCycles = periodCycles >> 1;
  // [R15] time-out only under serial control
  assign timeoutMode = spiCtl && timeoutModeSelect;
  assign rsvdPeriod = (periodMs == `WDSFS_PERIOD_W'(0));

  // ==========================================================
  // watchdog timer and error counter
  wdsfs_wd_t wdState;
  wdsfs_wd_t next_wdState;
  logic [31:0] winCnt;
  logic [31:0] next_winCnt;
  logic [3:0] errCnt;
  logic [3:0] next_errCnt;
  logic [3:0] incCnt;
  logic [3:0] thrVal;
  logic errEvent;
  logic wrongTrig;
  logic goodTrig;
  logic fireReset;

  // classify each trigger and window end
  always_comb begin
    next_wdState = wdState;
    next_winCnt = winCnt;
    wrongTrig = 1'h0;
    goodTrig = 1'h0;
    errEvent = 1'h0;
    if (modeState != DEV_NORMAL || rsvdPeriod) begin
      // [R03] stopped outside normal mode
      next_wdState = WD_IDLE;
      next_winCnt = 32'h0;
    end else begin
      case (wdState)
        WD_IDLE: begin
          // [R02] first trigger starts timing
          if (trigEdge) begin
            next_wdState = WD_RUN;
          end
          next_winCnt = 32'h0;
        end
        WD_RUN: begin
          if (trigEdge) begin
            // [R25] [R17] closed half only in window mode
            if (!timeoutMode && winCnt < halfCycles) begin
              wrongTrig = 1'h1;
            end else begin
              goodTrig = 1'h1;
            end
            // [R26] restart timing
            next_winCnt = 32'h0;
          end else if (winCnt == periodCycles - 32'h1) begin
            // [R25] missed window
            errEvent = 1'h1;
            next_winCnt = 32'h0;
          end else begin
            next_winCnt = winCnt + 32'h1;
          end
        end
        default: begin
          next_wdState = WD_IDLE;
          next_winCnt = 32'h0;
        end
      endcase
    end
    errEvent = errEvent || wrongTrig;
  end

  // [R06] saturating up/down count
  always_comb begin
    incCnt = (errCnt == `WDSFS_ERR_MAX) ? `WDSFS_ERR_MAX : errCnt + 4'h1;
    next_errCnt = errCnt;
    if (errEvent) begin
      next_errCnt = incCnt;
    end else if (goodTrig && errCnt != `WDSFS_ERR_MIN) begin
      next_errCnt = errCnt - 4'h1;
    end
  end

  // [R07] [R08] [R09] threshold choice
  always_comb begin
    thrVal = `WDSFS_ERR_MIN;
    if (spiCtl && resetThresholdSelect == `WDSFS_THR_SEL_FIVE) begin
      thrVal = `WDSFS_THR_FIVE;
    end else if (spiCtl && resetThresholdSelect == `WDSFS_THR_SEL_NINE) begin
      thrVal = `WDSFS_THR_NINE;
    end
    fireReset = errEvent && (incCnt >= thrVal);
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wdState <= WD_IDLE;
      winCnt <= 32'h0;
      errCnt <= `WDSFS_ERR_START;
    end else begin
      wdState <= next_wdState;
      winCnt <= next_winCnt;
      errCnt <= next_errCnt;
    end
  end

  // ==========================================================
  // output pulses and levels
  logic [31:0] wdrCnt;
  logic [31:0] next_wdrCnt;
  logic [31:0] intCnt;
  logic [31:0] next_intCnt;
  logic next_limpOut;
  logic [1:0] next_modeField;

  // pulse stretchers so the host sees a reset or interrupt of fixed width
  always_comb begin
    next_wdrCnt = (wdrCnt != 32'h0) ? wdrCnt - 32'h1 : 32'h0;
    next_intCnt = (intCnt != 32'h0) ? intCnt - 32'h1 : 32'h0;
    if (fireReset) begin
      next_wdrCnt = 32'(PULSE_CYCLES);
    end
    // [R10] interrupt on wrong trigger
    if (wrongTrig) begin
      next_intCnt = 32'(PULSE_CYCLES);
    end
  end

  // limp latches on; only a low-power mode or power-up clears it
  always_comb begin
    next_limpOut = limpOut;
    // [R05] limp on at trigger level
    if (fireReset) begin
      next_limpOut = 1'h1;
    end
    case (modeState)
      // [R23] failsafe limp on
      DEV_FAILSAFE: next_limpOut = 1'h1;
      // [R04] limp off when idle
      DEV_SLEEP, DEV_STANDBY, DEV_PWRUP: next_limpOut = 1'h0;
      default: next_limpOut = next_limpOut;
    endcase
    case (modeState)
      DEV_SLEEP, DEV_FAILSAFE: next_modeField = `WDSFS_MODE_SLEEP;
      DEV_NORMAL: next_modeField = `WDSFS_MODE_NORMAL;
      default: next_modeField = `WDSFS_MODE_STANDBY;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wdrCnt <= 32'h0;
      intCnt <= 32'h0;
      supplyResetOutN <= 1'h0;
      watchdogResetOutN <= 1'h1;
      interruptOutN <= 1'h1;
      limpOut <= 1'h0;
      modeField <= `WDSFS_MODE_STANDBY;
      failsafeActive <= 1'h0;
      spiControlActive <= 1'h0;
      errorCount <= `WDSFS_ERR_START;
      periodReserved <= 1'h0;
    end else begin
      wdrCnt <= next_wdrCnt;
      intCnt <= next_intCnt;
      // [R18] undervoltage holds supply reset
      supplyResetOutN <= !uvLvl && (modeState != DEV_PWRUP);
      watchdogResetOutN <= (next_wdrCnt == 32'h0);
      interruptOutN <= (next_intCnt == 32'h0);
      limpOut <= next_limpOut;
      modeField <= next_modeField;
      failsafeActive <= (modeState == DEV_FAILSAFE);
      spiControlActive <= spiCtl;
      errorCount <= next_errCnt;
      periodReserved <= spiCtl && rsvdPeriod;
    end
  end
endmodule : wdsfs_top

/* File: wdsfs_map.svh */
// Purpose: constants for the watchdog and supply fault supervisor.
// Assumes: 100 MHz system clock; pin levels pre-decoded to three-level codes.
// Notes: periods are in milliseconds and are turned into cycles in the logic.
//
// Functional notes
// [R01] Strap on select pin fixes pin or serial control; floating means serial.
// [R02] Watchdog waits in normal mode for the first trigger before timing.
// [R03] Watchdog runs only in normal mode; stopped in standby and sleep.
// [R04] Limp-home output is off in sleep and standby.
// [R05] Error count reaching trigger level turns limp-home output on.
// [R06] Error counter up on each failure, down on correct trigger, floor zero.
// [R07] Default and under pin control every error pulses watchdog reset low.
// [R08] Serial control may move reset threshold to fifth or ninth failure.
// [R09] Error counter starts at four and is readable as a four-bit field.
// [R10] Interrupt output pulses low on every wrong trigger.
// [R11] Under pin control the three-level window pin picks window length.
// [R12] Window splits evenly into a closed half then an open half.
// [R13] Both trigger edges count, after a glitch-rejection filter.
// [R14] Host toggles trigger once per service; a pulse counts twice.
// [R15] Serial control bit picks window or time-out watchdog.
// [R16] Period in ms comes from timer and prescaler codes; some reserved.
// [R17] Time-out mode accepts a trigger anytime before expiry.
// [R18] Regulator undervoltage pulls supply reset low; persisting means sleep.
// [R19] Pin control: undervoltage timer restarts, then enable pin picks mode.
// [R20] Serial control: persisting undervoltage goes failsafe if enabled, else sleep.
// [R21] Pin control: overvoltage forces sleep, rechecks enable every 250 ms.
// [R22] Serial control: overvoltage goes failsafe if enabled, else sleep.
// [R23] Failsafe turns limp-home on; entered only when enabled.
// [R24] Mode field codes: standby 00, sleep 01, normal 10, 11 reserved.
// [R25] Closed-half trigger is wrong; no trigger by open-half end is missed.
// [R26] Window timing restarts from zero after each trigger or error.
`ifndef WDSFS_MAP_SVH
`define WDSFS_MAP_SVH

// ==========================================================
// timing
`define WDSFS_CLK_NS 10
`define WDSFS_NS_PER_MS 1000000
`define WDSFS_INACT_MS 250
`define WDSFS_PERIOD_W 15

// ==========================================================
// error counter and thresholds
`define WDSFS_ERR_START 4'h4
`define WDSFS_ERR_MAX 4'hF
`define WDSFS_ERR_MIN 4'h0
`define WDSFS_THR_FIVE 4'h5
`define WDSFS_THR_NINE 4'h9
`define WDSFS_THR_SEL_EVERY 2'h0
`define WDSFS_THR_SEL_FIVE 2'h1
`define WDSFS_THR_SEL_NINE 2'h2

// ==========================================================
// mode field codes and three-level pin codes
`define WDSFS_MODE_STANDBY 2'h0
`define WDSFS_MODE_SLEEP 2'h1
`define WDSFS_MODE_NORMAL 2'h2
`define WDSFS_MODE_RSVD 2'h3
`define WDSFS_TRI_LOW 2'h0
`define WDSFS_TRI_HIGH 2'h1
`define WDSFS_TRI_OPEN 2'h2

// ==========================================================
// pin-control window lengths in ms
`define WDSFS_PIN_WIN_LOW_MS 15'h0100
`define WDSFS_PIN_WIN_HIGH_MS 15'h0040
`define WDSFS_PIN_WIN_OPEN_MS 15'h0400

// ==========================================================
// conditioned input bus bit positions
`define WDSFS_IN_SEL 0
`define WDSFS_IN_WIN 2
`define WDSFS_IN_TRIG 4
`define WDSFS_IN_EN 5
`define WDSFS_IN_UV 6
`define WDSFS_IN_OV 7
`define WDSFS_IN_W 8

// ==========================================================
// period table, entry {timer,prescaler} at that index, zero means reserved
`define WDSFS_PERIOD_MS_TABLE { \
  15'h0000, 15'h0000, 15'h0000, 15'h0000, \
  15'h0000, 15'h0000, 15'h4F10, 15'h2800, \
  15'h2000, 15'h1800, 15'h1000, 15'h0800, \
  15'h0800, 15'h0600, 15'h0400, 15'h0200, \
  15'h0300, 15'h0200, 15'h0180, 15'h0100, \
  15'h0200, 15'h0180, 15'h0100, 15'h0080, \
  15'h0080, 15'h0060, 15'h0040, 15'h0020, \
  15'h0010, 15'h000C, 15'h0008, 15'h0004 }

`endif

/* File: wdsfs_pkg.sv */
// Purpose: shared types of the watchdog and supply fault supervisor.
// Assumes: nothing beyond SystemVerilog packages.
// Notes: state encodings are left to the tools.
package wdsfs_pkg;
  // three-level pin code, see the map header for values
  typedef logic [1:0] wdsfs_tri_t;
  // device operating modes
  typedef enum {DEV_PWRUP, DEV_STANDBY, DEV_SLEEP, DEV_NORMAL, DEV_FAILSAFE} wdsfs_mode_t;
  // watchdog timer states
  typedef enum {WD_IDLE, WD_RUN} wdsfs_wd_t;
endpackage : wdsfs_pkg

/* File: wdsfs_deglitch.sv */
// Purpose: two-flop synchroniser and glitch filter with edge pulse per bit.
// Assumes: inputs are asynchronous pins.
// Notes: a level change must persist FILT_CYCLES cycles to be accepted.
`timescale 1ns/1ps
module wdsfs_deglitch #(
  parameter int WIDTH = 8,
  parameter int FILT_CYCLES = 8
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] rawIn,
  output logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] edgePulse
);
  localparam int CW = $clog2(FILT_CYCLES + 1);

  // ==========================================================
  // per-bit conditioning
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_bit
      logic syncA;
      logic syncB;
      logic lvl;
      logic next_lvl;
      logic edg;
      logic next_edg;
      logic [CW-1:0] cnt;
      logic [CW-1:0] next_cnt;

      // filter: only the second flop is looked at
      always_comb begin
        next_lvl = lvl;
        next_edg = 1'h0;
        next_cnt = '0;
        if (syncB != lvl) begin
          if (cnt == CW'(FILT_CYCLES - 1)) begin
            next_lvl = syncB;
            next_edg = 1'h1;
          end else begin
            next_cnt = cnt + CW'(1);
          end
        end
      end

      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          syncA <= 1'h0;
          syncB <= 1'h0;
          lvl <= 1'h0;
          edg <= 1'h0;
          cnt <= '0;
        end else begin
          syncA <= rawIn[gi];
          syncB <= syncA;
          lvl <= next_lvl;
          edg <= next_edg;
          cnt <= next_cnt;
        end
      end

      assign level[gi] = lvl;
      assign edgePulse[gi] = edg;
    end
  endgenerate
endmodule : wdsfs_deglitch

/* File: wdsfs_monitor.sv */
// Purpose: port-level checker for the watchdog supply fault supervisor
// Assumes: one clock domain, reset active high, default output pulse widths
// Notes: pulse widths are measured by small low-time counters
`timescale 1ns/1ps
`include "wdsfs_map.svh"
module wdsfs_monitor #(
  parameter int PULSE_CYCLES = 16
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic regulatorUndervoltage,
  input wire logic supplyResetOutN,
  input wire logic watchdogResetOutN,
  input wire logic interruptOutN,
  input wire logic limpOut,
  input wire logic [1:0] modeField,
  input wire logic failsafeActive,
  input wire logic [3:0] errorCount
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic [7:0] intLow;
  logic [7:0] wdrLow;
  // ==========================================================
  // helpers
  // low-time counters clear while high, so a rise sees the whole width
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      intLow <= 8'h00;
      wdrLow <= 8'h00;
    end else begin
      intLow <= interruptOutN ? 8'h00 : intLow + 8'h01;
      wdrLow <= watchdogResetOutN ? 8'h00 : wdrLow + 8'h01;
    end
  end
  // undervoltage held well past the input filter
  sequence uvHeld;
    $rose(regulatorUndervoltage) ##1 regulatorUndervoltage[*8] ##1 regulatorUndervoltage[*8];
  endsequence
  sequence errStepUp;
    errorCount == $past(errorCount) + 4'h1;
  endsequence
  // ==========================================================
  // assertions
  AST_INT_WIDTH: assert property ($rose(interruptOutN) |-> intLow == PULSE_CYCLES)
    else $error("interrupt pulse width wrong");
  AST_WDR_WIDTH: assert property ($rose(watchdogResetOutN) |-> wdrLow == PULSE_CYCLES)
    else $error("watchdog reset pulse width wrong");
  AST_WDR_LIMP: assert property ($fell(watchdogResetOutN) |-> limpOut)
    else $error("limp output off at watchdog reset");
  AST_INT_COUNT: assert property ($fell(interruptOutN) && $past(errorCount) != 4'hF |->
    errStepUp) else $error("interrupt without error count step");
  AST_WDR_COUNT: assert property ($fell(watchdogResetOutN) &&
    $past(errorCount) != 4'hF |-> errStepUp) else $error("watchdog reset without count step");
  AST_ERR_STEP: assert property ($changed(errorCount) |->
    errorCount == $past(errorCount) + 4'h1 || errorCount + 4'h1 == $past(errorCount))
    else $error("error count moved by more than one");
  AST_IDLE_STABLE: assert property (modeField != `WDSFS_MODE_NORMAL &&
    $past(modeField) != `WDSFS_MODE_NORMAL |-> $stable(errorCount))
    else $error("error count moved outside normal mode");
  AST_LIMP_QUIET: assert property (!failsafeActive && modeField != `WDSFS_MODE_NORMAL &&
    $past(modeField, 2) != `WDSFS_MODE_NORMAL && !$past(failsafeActive, 2) |-> !limpOut)
    else $error("limp output on in sleep or standby");
  AST_UV_RESET: assert property (uvHeld |-> ##[0:4] !supplyResetOutN)
    else $error("supply reset not low on undervoltage");
  AST_MODE_CODE: assert property (modeField != `WDSFS_MODE_RSVD)
    else $error("reserved mode code shown");
endmodule : wdsfs_monitor

/* File: wdsfs_host_model.sv */
// Purpose: host side that services the watchdog trigger pin
// Assumes: service and glitch requests are one-cycle strobes
// Notes: a glitch inverts the pin for two cycles, shorter than the filter
`timescale 1ns/1ps
module wdsfs_host_model (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic svcReq,
  input wire logic glitchReq,
  output logic trigOut
);
  logic level;
  logic [1:0] glitchLeft;
  // ==========================================================
  // trigger pin
  // toggle per service, never pulse
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      level <= 1'b0;
      glitchLeft <= 2'h0;
    end else begin
      level <= svcReq ? ~level : level;
      glitchLeft <= glitchReq ? 2'h2 : (glitchLeft != 2'h0 ? glitchLeft - 2'h1 : 2'h0);
    end
  end
  assign trigOut = level ^ (glitchLeft != 2'h0);
endmodule : wdsfs_host_model

/* File: tb_top.sv */
// Purpose: self-checking bench for the watchdog supply fault supervisor
// Assumes: millisecond and inactivity counts shortened; inputs move at falling edges
// Notes: waits are fixed counts taken from the filter and window latencies
`timescale 1ns/1ps
`include "wdsfs_map.svh"
module tb_top;
  import wdsfs_pkg::*;
  localparam int MS = 10;
  localparam int INACT = 50;
  localparam int WIN = 64 * MS; // pin control, window pin high
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  wdsfs_tri_t selPin = `WDSFS_TRI_LOW;
  logic en = 1'b1, uv = 1'b0, ov = 1'b0, fsEn = 1'b0, toSel = 1'b0, wake = 1'b0;
  logic svcReq = 1'b0, glitchReq = 1'b0, trig;
  logic [1:0] preF = 2'h0, thrSel = 2'h0, mode;
  logic [2:0] codeF = 3'h0;
  logic supRstN, wdrN, intN, limp, fsAct, spiAct, perRsv;
  logic [3:0] errCnt;
  int failures = 0;
  int totalChecks = 0;
  // ==========================================================
  // clock, design and host
  always #5 sys_clk = ~sys_clk;
  wdsfs_top #(.CYCLES_PER_MS(MS), .INACT_CYCLES(INACT), .GLITCH_CYCLES(8), .PULSE_CYCLES(16))
  i_dut (.sys_clk(sys_clk), .rst(rst), .controlSelectOrChipSelect(selPin),
    .windowLengthSelectPin(`WDSFS_TRI_HIGH), .watchdogTriggerIn(trig), .enablePin(en),
    .regulatorUndervoltage(uv), .regulatorOvervoltage(ov), .spiModeField(2'h0),
    .spiModeWrite(1'b0), .failsafeEnable(fsEn), .timeoutModeSelect(toSel),
    .periodPrescalerField(preF), .periodCodeField(codeF), .resetThresholdSelect(thrSel),
    .wakeEvent(wake), .supplyResetOutN(supRstN), .watchdogResetOutN(wdrN),
    .interruptOutN(intN), .limpOut(limp), .modeField(mode), .failsafeActive(fsAct),
    .spiControlActive(spiAct), .errorCount(errCnt), .periodReserved(perRsv));
  wdsfs_host_model i_host (.sys_clk(sys_clk), .rst(rst), .svcReq(svcReq),
    .glitchReq(glitchReq), .trigOut(trig));
  // ==========================================================
  // shared tasks
  task automatic check(input string what, input logic [3:0] exp, input logic [3:0] got);
    totalChecks++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : cyc
  // one toggle, then wait out filter and output latency
  task automatic svc();
    svcReq = 1'b1;
    cyc(1);
    svcReq = 1'b0;
    cyc(16);
  endtask : svc
  task automatic doReset(input wdsfs_tri_t sel);
    rst = 1'b1;
    selPin = sel;
    cyc(6);
    rst = 1'b0;
    cyc(40);
  endtask : doReset
  // ==========================================================
  // scenarios
  task automatic t_pinWatchdog();
    doReset(`WDSFS_TRI_LOW);
    check("spiControlActive", 4'h0, spiAct);
    check("modeField", `WDSFS_MODE_NORMAL, mode);
    cyc(WIN + 100);
    check("errorCount", `WDSFS_ERR_START, errCnt);
    svc();
    check("errorCount", `WDSFS_ERR_START, errCnt);
    for (int i = 3; i >= -1; i--) begin
      cyc(WIN / 2 + 60);
      svc();
      check("errorCount", (i < 0) ? 4'h0 : 4'(i), errCnt);
    end
    glitchReq = 1'b1;
    cyc(1);
    glitchReq = 1'b0;
    cyc(20);
    check("errorCount", 4'h0, errCnt);
    cyc(40);
    svc();
    check("errorCount", 4'h1, errCnt);
    check("interruptOutN", 4'h0, intN);
    check("watchdogResetOutN", 4'h0, wdrN);
    check("limpOut", 4'h1, limp);
    cyc(WIN);
    check("errorCount", 4'h2, errCnt);
    check("interruptOutN", 4'h1, intN);
    check("watchdogResetOutN", 4'h0, wdrN);
    $display("t_pinWatchdog done");
  endtask : t_pinWatchdog
  task automatic t_pinModes();
    en = 1'b0;
    cyc(30);
    check("modeField", `WDSFS_MODE_SLEEP, mode);
    check("limpOut", 4'h0, limp);
    cyc(2 * WIN);
    check("errorCount", 4'h2, errCnt);
    en = 1'b1;
    uv = 1'b1;
    cyc(20);
    check("supplyResetOutN", 4'h0, supRstN);
    cyc(INACT + 30);
    check("modeField", `WDSFS_MODE_NORMAL, mode);
    uv = 1'b0;
    ov = 1'b1;
    cyc(20);
    check("supplyResetOutN", 4'h1, supRstN);
    check("modeField", `WDSFS_MODE_SLEEP, mode);
    ov = 1'b0;
    cyc(INACT + 30);
    check("modeField", `WDSFS_MODE_NORMAL, mode);
    $display("t_pinModes done");
  endtask : t_pinModes
  task automatic t_serial();
    thrSel = 2'h2;
    doReset(`WDSFS_TRI_OPEN);
    check("spiControlActive", 4'h1, spiAct);
    svc();
    svc();
    check("errorCount", 4'h5, errCnt);
    check("interruptOutN", 4'h0, intN);
    check("watchdogResetOutN", 4'h1, wdrN);
    thrSel = 2'h1;
    svc();
    check("watchdogResetOutN", 4'h0, wdrN);
    toSel = 1'b1;
    svc();
    check("errorCount", 4'h5, errCnt);
    cyc(40);
    check("errorCount", 4'h6, errCnt);
    {codeF, preF} = 5'h19;
    cyc(2);
    check("periodReserved", 4'h0, perRsv);
    {codeF, preF} = 5'h1A;
    cyc(2);
    check("periodReserved", 4'h1, perRsv);
    {codeF, preF} = 5'h1C;
    cyc(2);
    check("periodReserved", 4'h1, perRsv);
    {codeF, preF} = 5'h00;
    $display("t_serial done");
  endtask : t_serial
  task automatic t_serialFaults();
    fsEn = 1'b1;
    ov = 1'b1;
    cyc(20);
    check("failsafeActive", 4'h1, fsAct);
    check("limpOut", 4'h1, limp);
    ov = 1'b0;
    cyc(20);
    wake = 1'b1;
    cyc(1);
    wake = 1'b0;
    cyc(5);
    check("modeField", `WDSFS_MODE_STANDBY, mode);
    check("limpOut", 4'h0, limp);
    fsEn = 1'b0;
    uv = 1'b1;
    cyc(INACT + 30);
    check("modeField", `WDSFS_MODE_SLEEP, mode);
    check("failsafeActive", 4'h0, fsAct);
    uv = 1'b0;
    $display("t_serialFaults done");
  endtask : t_serialFaults
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", totalChecks, failures);
    if (failures == 0 && totalChecks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : tally_and_finish
  // ==========================================================
  // main sequence
  initial begin
    t_pinWatchdog();
    t_pinModes();
    t_serial();
    t_serialFaults();
    tally_and_finish();
  end
endmodule : tb_top
bind wdsfs_top wdsfs_monitor #(.PULSE_CYCLES(PULSE_CYCLES)) u_mon (.sys_clk(sys_clk),
  .rst(rst), .regulatorUndervoltage(regulatorUndervoltage), .supplyResetOutN(supplyResetOutN),
  .watchdogResetOutN(watchdogResetOutN), .interruptOutN(interruptOutN), .limpOut(limpOut),
  .modeField(modeField), .failsafeActive(failsafeActive), .errorCount(errorCount));
